// ### include/dmsl_consts.svh
// constants of the dot matrix serial loader, both ends
// assumes both ends run on one 125 MHz clk
// Behaviour
// RL1 - dot latches form 20 columns, 8 rows
// RL2 - latches 0..7 drive left-most column
// RL3 - host sends left-most character first
// RL4 - control load: select high, enable low, 8 bits
// RL5 - control word copied at clock low after enable
// RL6 - bit 7 picks control word 0 or 1
// RL7 - control bytes go most significant bit first
// RL8 - word 0 holds brightness, current, sleep
// RL9 - sleep stops oscillator and pixel drivers
// RL10 - serial mode: data out is stage 7
// RL11 - simultaneous mode: data out follows data in
// RL12 - chained loads need N times 8 pulses
// RL13 - word 1 bit 1 divides external oscillator by 8
// RL14 - refresh takes 512 display clocks
// RL15 - prescaler leaves internal oscillator alone
// RL16 - host writes zeros in word 1 bits 2..6
// RL17 - chained dot registers form one long register
// RL18 - host writes every chip's control word
// RL19 - shared bus lines, data chained leftward
// RL20 - internal oscillator or master's oscillator
// RL21 - dot load: select low, enable low, 160 bits
// RL22 - dot latch at clock low after enable
// RL23 - reset clears control words, keeps dots
// RL24 - select sampled at enable falling edge
`ifndef DMSL_CONSTS_SVH
`define DMSL_CONSTS_SVH

`define DMSL_DOT_BITS      160
`define DMSL_COLS          20
`define DMSL_ROWS          8
`define DMSL_ROW_W         3
`define DMSL_CTRL_BITS     8
`define DMSL_CW_BITS       7
`define DMSL_SEL_BIT       7
`define DMSL_SLEEP_BIT     6
`define DMSL_PEAK_LO       4
`define DMSL_PWM_HI        3
`define DMSL_SIMUL_BIT     0
`define DMSL_PRESC_BIT     1
`define DMSL_REFRESH_W     9
`define DMSL_REFRESH_CYC   512
`define DMSL_SLOT_W        6
`define DMSL_ROW_ON        6'h3C
`define DMSL_PRESC_LAST    3'h7
`define DMSL_PWM_STEP      7'h04
`define DMSL_CLK_NS        8
`define DMSL_HALF_NS       100
`define DMSL_HALF_CYC      ((`DMSL_HALF_NS + `DMSL_CLK_NS - 1) / `DMSL_CLK_NS)
`define DMSL_INT_OSC_DIV   625
`define DMSL_REG_CFG       4'h0
`define DMSL_REG_DATA      4'h1
`define DMSL_REG_STATUS    4'h2
`define DMSL_REG_RX        4'h3
`define DMSL_CFG_TARGET    0
`define DMSL_CFG_LAST      1
`define DMSL_CFG_BLANK     2
`define DMSL_CFG_RESET     3
`define DMSL_CFG_EXTOSC    4

`endif

// ### include/dmsl_pkg.sv
// types shared by the loader ends
// assumes dmsl_consts.svh on the include path
`include "dmsl_consts.svh"
`default_nettype none
package dmsl_pkg;
   typedef enum logic [2:0] {
      DMSL_IDLE  = 3'h0,
      DMSL_SEL   = 3'h1,
      DMSL_EN    = 3'h3,
      DMSL_LOW   = 3'h2,
      DMSL_HIGH  = 3'h6,
      DMSL_FINCE = 3'h7,
      DMSL_FINLO = 3'h5,
      DMSL_WAIT  = 3'h4
   } dmsl_state_t;

   typedef struct packed {
      logic                        sclk_d;
      logic                        ce_d;
      logic                        active;
      logic                        to_ctrl;
      logic [`DMSL_DOT_BITS-1:0]   dot_sr;
      logic [`DMSL_DOT_BITS-1:0]   dot_lat;
      logic [`DMSL_CTRL_BITS-1:0]  ctrl_sr;
      logic [`DMSL_CW_BITS-1:0]    cw0;
      logic [`DMSL_CW_BITS-1:0]    cw1;
      logic [15:0]                 osc_cnt;
      logic                        osc_lvl;
      logic                        ext_d;
      logic [2:0]                  pre_cnt;
      logic [`DMSL_REFRESH_W-1:0]  ref_cnt;
      logic [`DMSL_COLS-1:0]       col;
      logic [`DMSL_ROWS-1:0]       row;
   } dmsl_dev_t;

   typedef struct packed {
      dmsl_state_t st;
      logic [7:0]  cnt;
      logic [3:0]  bit_cnt;
      logic [7:0]  tx;
      logic [7:0]  rx;
      logic [4:0]  cfg;
      logic        sclk;
      logic        ce_n;
      logic        ts;
      logic        din;
      logic [7:0]  rdata;
   } dmsl_host_t;
endpackage
`default_nettype wire

// ### include/dmsl_link_if.sv
// serial link between host and display driver
// assumes the bench joins both ends through it
`default_nettype none
interface dmsl_link_if;
   logic ce_n;
   logic target_select;
   logic sclk;
   logic din;
   logic dout;
   logic reset_n;
   logic blank_input;
   logic osc_in;

   // bused lines all driven by the host [RL19]
   modport host (
      output ce_n,
      output target_select,
      output sclk,
      output din,
      input  dout,
      output reset_n,
      output blank_input,
      output osc_in
   );
   modport dev (
      input  ce_n,
      input  target_select,
      input  sclk,
      input  din,
      output dout,
      input  reset_n,
      input  blank_input,
      input  osc_in
   );
endinterface
`default_nettype wire

// ### verilog/dmsl_sync.sv
// two-stage synchroniser for a group of pins
// assumes the pins are asynchronous to clk
`default_nettype none
module dmsl_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         arst_n,
   input  wire logic [W-1:0] async_in,
   output var  logic [W-1:0] sync_out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } dmsl_sync_st_t;

   dmsl_sync_st_t r_reg;
   dmsl_sync_st_t r_next;

   if (W < 1) begin : g_chk
      $error("dmsl_sync width must be positive");
   end

   always_comb begin
      r_next    = r_reg;
      r_next.s1 = async_in;
      r_next.s2 = r_reg.s1;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign sync_out = r_reg.s2;
endmodule
`default_nettype wire

// ### verilog/dmsl_dev.sv
// display driver end: dot and control shift registers, refresh
// assumes host pins arrive asynchronously and are synchronised here
`include "dmsl_consts.svh"
`default_nettype none
module dmsl_dev #(
   parameter int INT_OSC_DIV = `DMSL_INT_OSC_DIV
) (
   input  wire logic                     clk,
   input  wire logic                     arst_n,
   dmsl_link_if.dev                      link,
   input  wire logic                     osc_slave,
   output var  logic [`DMSL_COLS-1:0]    col_drive,
   output var  logic [`DMSL_ROWS-1:0]    row_sink,
   output var  logic [1:0]               peak_current,
   output var  logic [3:0]               pwm_level,
   output var  logic                     awake,
   output var  logic                     osc_out
);
   localparam int NSYNC = 7;

   dmsl_pkg::dmsl_dev_t             r_reg;
   dmsl_pkg::dmsl_dev_t             r_next;
   logic [NSYNC-1:0]                pins_s;
   logic                            ce_s;
   logic                            ts_s;
   logic                            sclk_s;
   logic                            din_s;
   logic                            rst_s;
   logic                            blank_s;
   logic                            osc_s;
   logic                            sclk_rise;
   logic                            ext_rise;
   logic                            ext_tick;
   logic                            int_tick;
   logic                            int_disp;
   logic                            disp_tick;
   logic                            is_awake;
   logic                            lit;
   logic [`DMSL_ROW_W-1:0]          row_idx;
   logic [`DMSL_SLOT_W-1:0]         slot;
   logic [6:0]                      on_lim;
   logic [`DMSL_COLS-1:0]           col_sel;

   if (INT_OSC_DIV < 2 || INT_OSC_DIV > 65535) begin : g_chk
      $error("INT_OSC_DIV out of range");
   end

   dmsl_sync #(
      .W (NSYNC)
   ) u_sync (
      .clk      (clk),
      .arst_n   (arst_n),
      .async_in ({link.ce_n, link.target_select, link.sclk, link.din,
                  link.reset_n, link.blank_input, link.osc_in}),
      .sync_out (pins_s)
   );

   assign ce_s    = pins_s[6];
   assign ts_s    = pins_s[5];
   assign sclk_s  = pins_s[4];
   assign din_s   = pins_s[3];
   assign rst_s   = pins_s[2];
   assign blank_s = pins_s[1];
   assign osc_s   = pins_s[0];

   assign sclk_rise = sclk_s & ~r_reg.sclk_d;
   assign ext_rise  = osc_s & ~r_reg.ext_d;

   // sleep bit low means asleep [RL9]
   assign is_awake = r_reg.cw0[`DMSL_SLEEP_BIT];

   // internal oscillator, untouched by the prescaler [RL15]
   assign int_tick = is_awake && (r_reg.osc_cnt == 16'(INT_OSC_DIV - 1));
   assign int_disp = int_tick & ~r_reg.osc_lvl;

   // external clock direct or divided by eight [RL13]
   assign ext_tick = r_reg.cw1[`DMSL_PRESC_BIT] ?
                     (ext_rise && r_reg.pre_cnt == `DMSL_PRESC_LAST) : ext_rise;

   // slave runs from the master's oscillator [RL20]
   assign disp_tick = is_awake & (osc_slave ? ext_tick : int_disp);

   // refresh of 512 display clocks, 64 per row [RL14]
   assign row_idx = r_reg.ref_cnt[`DMSL_REFRESH_W-1:`DMSL_SLOT_W];
   assign slot    = r_reg.ref_cnt[`DMSL_SLOT_W-1:0];

   // on-time grows with the brightness code up to code 14; code 15 gives the same 60 slots [RL8]
   assign on_lim = {1'b0, r_reg.cw0[`DMSL_PWM_HI:0], 2'b00} + `DMSL_PWM_STEP;

   // row 0 carries no LEDs, so it is never lit [RL1]
   assign lit = is_awake && !blank_s && (slot < `DMSL_ROW_ON) &&
                ({1'b0, slot} < on_lim) && (row_idx != '0);

   // column c shows latches c*8..c*8+7, row 1 at the bottom [RL1] [RL2]
   for (genvar c = 0; c < `DMSL_COLS; c++) begin : g_col
      assign col_sel[c] = r_reg.dot_lat[c * `DMSL_ROWS + int'(row_idx)];
   end

   always_comb begin
      r_next        = r_reg;
      r_next.sclk_d = sclk_s;
      r_next.ce_d   = ce_s;
      r_next.ext_d  = osc_s;

      if (r_reg.ce_d && !ce_s) begin
         // target fixed for the whole transfer [RL24]
         r_next.active  = 1'b1;
         r_next.to_ctrl = ts_s;
      end else if (r_reg.active && !ce_s && sclk_rise) begin
         if (r_reg.to_ctrl) begin
            // bit 7 enters first and ends in the top stage [RL7] [RL4]
            r_next.ctrl_sr = {r_reg.ctrl_sr[`DMSL_CTRL_BITS-2:0], din_s};
         end else begin
            // first bit ends at bit 0; bit 0 feeds the next chip [RL17] [RL21]
            r_next.dot_sr = {din_s, r_reg.dot_sr[`DMSL_DOT_BITS-1:1]};
         end
      end else if (r_reg.active && ce_s && !sclk_s) begin
         r_next.active = 1'b0;
         if (r_reg.to_ctrl) begin
            // only the selected word changes [RL5] [RL6]
            if (r_reg.ctrl_sr[`DMSL_SEL_BIT]) begin
               r_next.cw1 = r_reg.ctrl_sr[`DMSL_CW_BITS-1:0];
            end else begin
               r_next.cw0 = r_reg.ctrl_sr[`DMSL_CW_BITS-1:0];
            end
         end else begin
            // old pattern stays shown until this copy [RL22]
            r_next.dot_lat = r_reg.dot_sr;
         end
      end

      if (!is_awake) begin
         // oscillator held stopped while asleep [RL9]
         r_next.osc_cnt = '0;
         r_next.osc_lvl = 1'b0;
      end else if (int_tick) begin
         r_next.osc_cnt = '0;
         r_next.osc_lvl = ~r_reg.osc_lvl;
      end else begin
         r_next.osc_cnt = r_reg.osc_cnt + 16'h0001;
      end

      if (!r_reg.cw1[`DMSL_PRESC_BIT]) begin
         r_next.pre_cnt = '0;
      end else if (ext_rise) begin
         r_next.pre_cnt = r_reg.pre_cnt + 3'h1;
      end

      if (disp_tick) begin
         // nine-bit counter wraps after one full refresh [RL14]
         r_next.ref_cnt = r_reg.ref_cnt + 9'h001;
      end

      // drivers dark when asleep or blanked [RL9]
      r_next.col = lit ? col_sel : '0;
      r_next.row = lit ? (`DMSL_ROWS'(1) << row_idx) : '0;

      if (!rst_s) begin
         // reset pin clears control state only; dots survive [RL23]
         r_next.cw0     = '0;
         r_next.cw1     = '0;
         r_next.ctrl_sr = '0;
         r_next.active  = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   // raw pin passthrough: chained chips must shift on the same edge [RL11]
   always_comb begin
      if (r_reg.active && r_reg.to_ctrl && r_reg.cw1[`DMSL_SIMUL_BIT]) begin
         link.dout = link.din;
      end else if (r_reg.to_ctrl) begin
         // serial mode shows the last stage [RL10]
         link.dout = r_reg.ctrl_sr[`DMSL_CTRL_BITS-1];
      end else begin
         link.dout = r_reg.dot_sr[0];
      end
   end

   assign col_drive    = r_reg.col;
   assign row_sink     = r_reg.row;
   assign peak_current = r_reg.cw0[`DMSL_SLEEP_BIT-1:`DMSL_PEAK_LO];
   assign pwm_level    = r_reg.cw0[`DMSL_PWM_HI:0];
   assign awake        = is_awake;
   assign osc_out      = r_reg.osc_lvl;
endmodule
`default_nettype wire

// ### verilog/dmsl_host.sv
// host end: turns register writes into serial frames
// assumes a single-cycle register master on clk
`include "dmsl_consts.svh"
`default_nettype none
module dmsl_host #(
   parameter int HALF_CYC = `DMSL_HALF_CYC
) (
   input  wire logic       clk,
   input  wire logic       arst_n,
   dmsl_link_if.host       link,
   input  wire logic [3:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output var  logic [7:0] rdata,
   input  wire logic       ext_osc
);
   dmsl_pkg::dmsl_host_t r_reg;
   dmsl_pkg::dmsl_host_t r_next;
   logic                 dout_s;
   logic                 done;
   logic                 busy;
   logic                 data_wr;

   if (HALF_CYC < 1 || HALF_CYC > 255) begin : g_chk
      $error("HALF_CYC out of range");
   end

   dmsl_sync #(
      .W (1)
   ) u_sync (
      .clk      (clk),
      .arst_n   (arst_n),
      .async_in (link.dout),
      .sync_out (dout_s)
   );

   assign done    = (r_reg.cnt == 8'h00);
   assign busy    = (r_reg.st != dmsl_pkg::DMSL_IDLE) && (r_reg.st != dmsl_pkg::DMSL_WAIT);
   assign data_wr = wr && (addr == `DMSL_REG_DATA);

   always_comb begin
      r_next       = r_reg;
      r_next.rdata = 8'h00;
      if (r_reg.cnt != 8'h00) begin
         r_next.cnt = r_reg.cnt - 8'h01;
      end
      if (wr && addr == `DMSL_REG_CFG) begin
         r_next.cfg = wdata[4:0];
      end
      if (rd) begin
         case (addr)
            `DMSL_REG_CFG:    r_next.rdata = {3'h0, r_reg.cfg};
            `DMSL_REG_STATUS: r_next.rdata = {6'h00, r_reg.st == dmsl_pkg::DMSL_WAIT, busy};
            `DMSL_REG_RX:     r_next.rdata = r_reg.rx;
            default:          r_next.rdata = 8'h00;
         endcase
      end
      case (r_reg.st)
         dmsl_pkg::DMSL_IDLE: begin
            if (data_wr) begin
               // byte sent as given, reserved zeros are software's [RL16] [RL3]
               r_next.tx   = wdata;
               r_next.ts   = r_reg.cfg[`DMSL_CFG_TARGET];
               r_next.ce_n = 1'b1;
               r_next.sclk = 1'b0;
               r_next.cnt  = 8'(HALF_CYC - 1);
               r_next.st   = dmsl_pkg::DMSL_SEL;
            end
         end
         dmsl_pkg::DMSL_SEL: begin
            if (done) begin
               // select settles before enable drops [RL4] [RL21]
               r_next.ce_n = 1'b0;
               r_next.cnt  = 8'(HALF_CYC - 1);
               r_next.st   = dmsl_pkg::DMSL_EN;
            end
         end
         dmsl_pkg::DMSL_EN: begin
            if (done) begin
               r_next.din = r_reg.tx[7];
               r_next.cnt = 8'(HALF_CYC - 1);
               r_next.st  = dmsl_pkg::DMSL_LOW;
            end
         end
         dmsl_pkg::DMSL_LOW: begin
            if (done) begin
               r_next.sclk    = 1'b1;
               r_next.rx      = {r_reg.rx[6:0], dout_s};
               r_next.tx      = {r_reg.tx[6:0], 1'b0};
               r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
               r_next.cnt     = 8'(HALF_CYC - 1);
               r_next.st      = dmsl_pkg::DMSL_HIGH;
            end
         end
         dmsl_pkg::DMSL_HIGH: begin
            if (done) begin
               r_next.cnt = 8'(HALF_CYC - 1);
               if (r_reg.bit_cnt == 4'h8) begin
                  // eight pulses per byte; chains take N bytes [RL12] [RL18]
                  r_next.bit_cnt = 4'h0;
                  if (r_reg.cfg[`DMSL_CFG_LAST]) begin
                     r_next.ce_n = 1'b1;
                     r_next.st   = dmsl_pkg::DMSL_FINCE;
                  end else begin
                     r_next.st = dmsl_pkg::DMSL_WAIT;
                  end
               end else begin
                  // most significant bit goes first [RL7]
                  r_next.din  = r_reg.tx[7];
                  r_next.sclk = 1'b0;
                  r_next.st   = dmsl_pkg::DMSL_LOW;
               end
            end
         end
         dmsl_pkg::DMSL_WAIT: begin
            if (data_wr) begin
               r_next.tx   = wdata;
               r_next.din  = wdata[7];
               r_next.sclk = 1'b0;
               r_next.cnt  = 8'(HALF_CYC - 1);
               r_next.st   = dmsl_pkg::DMSL_LOW;
            end
         end
         dmsl_pkg::DMSL_FINCE: begin
            if (done) begin
               // clock low with enable high makes the chip copy [RL5] [RL22]
               r_next.sclk = 1'b0;
               r_next.cnt  = 8'(HALF_CYC - 1);
               r_next.st   = dmsl_pkg::DMSL_FINLO;
            end
         end
         dmsl_pkg::DMSL_FINLO: begin
            if (done) begin
               r_next.st = dmsl_pkg::DMSL_IDLE;
            end
         end
         default: begin
            r_next.st   = dmsl_pkg::DMSL_IDLE;
            r_next.ce_n = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         r_reg      <= '0;
         r_reg.ce_n <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   assign link.ce_n          = r_reg.ce_n;
   assign link.target_select = r_reg.ts;
   assign link.sclk          = r_reg.sclk;
   assign link.din           = r_reg.din;
   assign link.reset_n       = ~r_reg.cfg[`DMSL_CFG_RESET];
   assign link.blank_input   = r_reg.cfg[`DMSL_CFG_BLANK];
   assign link.osc_in        = r_reg.cfg[`DMSL_CFG_EXTOSC] & ext_osc;
   assign rdata              = r_reg.rdata;
endmodule
`default_nettype wire

// ### sim/dmsl_assertions.sv
// link checks between host and display driver ends
// assumes the host runs with a half period of 3 clk cycles
`default_nettype none
module dmsl_assertions (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic ce_n,
   input wire logic target_select,
   input wire logic sclk,
   input wire logic din
);
   logic [8:0] rise_cnt_reg;
   logic       sclk_d_reg;

   // counts clock rises of one frame, cleared while enable is high
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rise_cnt_reg <= 9'h000;
         sclk_d_reg   <= 1'b0;
      end else begin
         sclk_d_reg <= sclk;
         if (ce_n)
            rise_cnt_reg <= 9'h000;
         else if (sclk && !sclk_d_reg)
            rise_cnt_reg <= rise_cnt_reg + 9'h001;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   sel_hold_a: assert property (!ce_n |-> $stable(target_select))
      else $error("target select moved inside a frame");
   ce_fall_a: assert property ($fell(ce_n) |-> !sclk [*4])
      else $error("clock rose too soon after enable fell");
   ce_rise_a: assert property ($rose(ce_n) |-> sclk ##[1:6] !sclk)
      else $error("clock did not fall after enable rose");
   din_hold_a: assert property (sclk |-> $stable(din))
      else $error("data changed while clock high");
   sclk_gate_a: assert property ($rose(sclk) |-> !ce_n)
      else $error("clock rose outside a frame");
   sclk_high_a: assert property ($rose(sclk) |-> sclk [*3])
      else $error("clock high phase too short");
   sclk_low_a: assert property ($fell(sclk) |-> !sclk [*3])
      else $error("clock low phase too short");
   ctrl_count_a: assert property ($rose(ce_n) && target_select |-> rise_cnt_reg == 9'h008)
      else $error("control frame not eight bits");
   dot_count_a: assert property ($rose(ce_n) && !target_select |-> rise_cnt_reg == 9'h0A0)
      else $error("dot frame not 160 bits");

   ctrl_end_c: cover property ($rose(ce_n) && target_select);
   dot_end_c: cover property ($rose(ce_n) && !target_select);
   ctrl_start_c: cover property ($fell(ce_n) && target_select);
endmodule
`default_nettype wire

// ### sim/dmsl_tb.sv
// bench joining host and display driver ends over the link
// assumes design files, package and link interface compiled first
`include "dmsl_consts.svh"
`default_nettype none
module dmsl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [7:0]  wdata = 8'h00;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [7:0]  rdata;
   logic        ext_osc = 1'b0;
   logic [1:0]  ext_div = 2'h0;
   logic        osc_slave = 1'b0;
   logic [7:0]  cfg_base = 8'h00;
   logic [19:0] col_drive;
   logic [7:0]  row_sink;
   logic [1:0]  peak_current;
   logic [3:0]  pwm_level;
   logic        awake;
   logic        osc_out;
   int          bad_count = 0;
   int          comparisons = 0;

   dmsl_link_if link ();
   dmsl_host #(.HALF_CYC(3)) u_dmsl_host (.clk(clk), .arst_n(arst_n), .link(link), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ext_osc(ext_osc));
   dmsl_dev #(.INT_OSC_DIV(2)) u_dmsl_dev (.clk(clk), .arst_n(arst_n), .link(link),
      .osc_slave(osc_slave), .col_drive(col_drive), .row_sink(row_sink),
      .peak_current(peak_current), .pwm_level(pwm_level), .awake(awake), .osc_out(osc_out));
   dmsl_assertions u_dmsl_assertions (.clk(clk), .arst_n(arst_n), .ce_n(link.ce_n),
      .target_select(link.target_select), .sclk(link.sclk), .din(link.din));

   always #4 clk = ~clk;
   // external oscillator of 4 clk period, slow enough for the pin synchroniser
   always @(posedge clk) begin
      ext_div <= ext_div + 2'h1;
      ext_osc <= ext_div[1];
   end

   task automatic complete_run();
      if (bad_count == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic check_val(input string what, input logic [19:0] exp, input logic [19:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   // polls until the host is idle or waiting for the next byte
   task automatic send_byte(input logic [7:0] d);
      logic [7:0] s;
      int n;
      wr_reg(`DMSL_REG_DATA, d);
      s = 8'h01;
      n = 0;
      while (s[0] === 1'b1 && s[1] !== 1'b1 && n < 100) begin
         rd_reg(`DMSL_REG_STATUS, s);
         n++;
      end
      check_val("frame end", 20'h0, (n == 100) ? 20'h1 : 20'h0);
   endtask

   task automatic ctrl_load(input logic [7:0] b);
      wr_reg(`DMSL_REG_CFG, cfg_base | 8'h03);
      send_byte(b);
      repeat (10) @(posedge clk);
   endtask

   task automatic dot_load(input logic [7:0] first_b, input logic [7:0] last_b);
      wr_reg(`DMSL_REG_CFG, cfg_base);
      send_byte(first_b);
      for (int i = 1; i < 19; i++)
         send_byte(8'h00);
      wr_reg(`DMSL_REG_CFG, cfg_base | 8'h02);
      send_byte(last_b);
      repeat (10) @(posedge clk);
   endtask

   // waits for the next onset of row pattern r; t is the cycles spent
   task automatic wait_row(input logic [7:0] r, output int t);
      t = 0;
      while (row_sink === r && t < 40000) begin
         @(posedge clk);
         #1;
         t++;
      end
      while (row_sink !== r && t < 40000) begin
         @(posedge clk);
         #1;
         t++;
         if (row_sink[0] === 1'b1)
            check_val("row 0 lit", 20'h0, 20'h1);
      end
      if (t >= 40000)
         check_val("row wait", 20'h0, 20'h1);
   endtask

   task automatic check_pixels();
      int t;
      wait_row(8'h02, t);
      check_val("row 1 columns", 20'h00001, col_drive);
      wait_row(8'h80, t);
      check_val("row 7 columns", 20'h80000, col_drive);
   endtask

   task automatic test_words();
      logic [7:0] b [2] = '{8'h4D, 8'h7A};
      for (int i = 0; i < 2; i++) begin
         wr_reg(`DMSL_REG_CFG, 8'h03);
         wr_reg(`DMSL_REG_DATA, b[i]);
         repeat (6) @(posedge clk);
         #1;
         check_val("pwm in load", (i == 0) ? 20'h0 : 20'hD, pwm_level);
         send_byte(8'h00);
         repeat (10) @(posedge clk);
         check_val("pwm", 20'(b[i][3:0]), pwm_level);
         check_val("peak", 20'(b[i][5:4]), peak_current);
         check_val("awake", 20'h1, awake);
      end
      ctrl_load(8'h80);
      check_val("pwm kept", 20'hA, pwm_level);
   endtask

   task automatic test_sleep_reset();
      logic seen;
      int   hi;
      seen = 1'b0;
      hi   = 0;
      ctrl_load(8'h0F);
      check_val("sleep awake", 20'h0, awake);
      repeat (40) begin
         @(posedge clk);
         #1;
         if (osc_out !== 1'b0 || row_sink !== 8'h00)
            seen = 1'b1;
      end
      check_val("sleep quiet", 20'h0, seen);
      ctrl_load(8'h4F);
      check_pixels();
      // blank pin darkens rows while the oscillator keeps running
      wr_reg(`DMSL_REG_CFG, 8'h04);
      repeat (4) @(posedge clk);
      seen = 1'b0;
      repeat (300) begin
         @(posedge clk);
         #1;
         if (row_sink !== 8'h00)
            seen = 1'b1;
         if (osc_out === 1'b1)
            hi++;
      end
      check_val("blank dark", 20'h0, seen);
      check_val("osc running", 20'd150, 20'(hi));
      wr_reg(`DMSL_REG_CFG, 8'h08);
      repeat (10) @(posedge clk);
      wr_reg(`DMSL_REG_CFG, 8'h00);
      repeat (10) @(posedge clk);
      check_val("pin reset awake", 20'h0, awake);
      check_val("pin reset pwm", 20'h0, pwm_level);
      ctrl_load(8'h4F);
      check_pixels();
   endtask

   task automatic test_simul();
      logic [7:0] v;
      ctrl_load(8'h81);
      ctrl_load(8'h4A);
      rd_reg(`DMSL_REG_RX, v);
      check_val("simultaneous out", 20'h4A, v);
      check_val("simultaneous pwm", 20'hA, pwm_level);
      ctrl_load(8'h80);
      ctrl_load(8'h4F);
      // serial mode shifts out the byte held before this load
      rd_reg(`DMSL_REG_RX, v);
      check_val("serial out", 20'h80, v);
   endtask

   // refresh period taken between two onsets of row 1
   task automatic measure(input logic [19:0] exp, input string what);
      int t;
      wait_row(8'h02, t);
      wait_row(8'h02, t);
      check_val(what, exp, 20'(t));
   endtask

   task automatic test_refresh();
      measure(20'd2048, "internal period");
      @(posedge clk);
      osc_slave <= 1'b1;
      cfg_base = 8'h10;
      wr_reg(`DMSL_REG_CFG, cfg_base);
      measure(20'd2048, "external period");
      ctrl_load(8'h82);
      measure(20'd16384, "prescaled period");
   endtask

   initial begin
      logic [7:0] v;
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      #1;
      check_val("reset awake", 20'h0, awake);
      check_val("reset pwm", 20'h0, pwm_level);
      check_val("reset rows", 20'h0, row_sink);
      rd_reg(4'hF, v);
      check_val("unmapped read", 20'h0, v);
      test_words();
      ctrl_load(8'h4F);
      dot_load(8'hC0, 8'h01);
      check_pixels();
      test_sleep_reset();
      test_simul();
      test_refresh();
      complete_run();
   end

   initial begin
      #(100000 * 8);
      bad_count++;
      complete_run();
   end
endmodule
`default_nettype wire
